// [design/ramp_soak_profile_sequencer.sv]
/*
 Ramp-and-soak setpoint profile sequencer with an Avalon-MM register slave.
 Assumes process_value and power_ok are synchronous to mclk and that the
 profile store is retained across a power loss signalled by power_ok.
*/
`timescale 1ns/1ps
`include "seq_map.svh"
// Function
// - Store twenty programs of up to nine segments, each with target and duration.
// - Selecting a defined program and starting it generates the setpoint automatically.
// - A zero-duration segment ends the program; later segments are skipped.
// - Deviation beyond tolerance pauses segment timing until back within band.
// - Zero tolerance disables the deviation check; time has priority.
// - Segment durations accept up to 9999 seconds or minutes.
// - A finished program immediately starts the program named by its link.
// - Self links or a chain back to its first program repeat forever.
// - Each segment has an event mask driving alarm outputs while it runs.
// - Segment events act only on alarms set to the event-alarm function.
// - Nonzero tolerance delays the start until process value reaches initial setpoint.
// - After power returns the interrupted segment restarts from its beginning.
module ramp_soak_profile_sequencer #(
  parameter int SEC_CYCLES = `SEC_CYCLES,
  parameter int NPROG = `NUM_PROGS,
  parameter int NSEG = `NUM_SEGS
) (
  input logic mclk,
  input logic arst_n,
  input logic [13:0] address,
  input logic read,
  input logic write,
  input logic [31:0] writedata,
  input logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input logic signed [15:0] process_value,
  input logic power_ok,
  output logic signed [15:0] setpoint,
  output logic [3:0] event_alarms,
  output logic irq
);

  function automatic logic [16:0] absdiff(input logic signed [15:0] a,
                                          input logic signed [15:0] b);
    logic signed [16:0] d;
    d = 17'(a) - 17'(b);
    absdiff = d[16] ? 17'(-d) : d;
  endfunction

  function automatic logic signed [15:0] ramp(input logic signed [15:0] s,
                                              input logic signed [15:0] t,
                                              input logic [13:0] e,
                                              input logic [13:0] d);
    logic signed [31:0] p;
    if (d == 14'h0) begin
      p = 32'(t) - 32'(s);
    end else begin
      p = ((32'(t) - 32'(s)) * $signed(32'(e))) / $signed(32'(d));
    end
    ramp = 16'(32'(s) + p);
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] o,
                                           input logic [31:0] w,
                                           input logic [3:0] b);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        m[8*i +: 8] = w[8*i +: 8];
      end
    end
    be_merge = m;
  endfunction

  logic signed [15:0] sp_mem [NPROG][NSEG+1];
  logic [13:0] dur_mem [NPROG][NSEG];
  logic [3:0] ev_mem [NPROG][NSEG];
  logic [4:0] link_mem [NPROG];

  seq_pkg::ctrl_t ctrl_reg;
  logic [4:0] sel_reg;
  logic [15:0] tol_reg;
  logic [3:0] evfunc_reg;
  logic [3:0] irq_mask_reg;
  logic [3:0] irq_stat_reg;
  seq_pkg::seq_state_t state_reg;
  logic [4:0] prog_reg;
  logic [3:0] seg_reg;
  logic [13:0] elap_reg;
  logic hold_reg;
  logic run_d_reg;
  logic pwr_d_reg;
  logic [24:0] sec_cnt_reg;
  logic [5:0] min_cnt_reg;
  logic tick_reg;
  logic signed [15:0] setpoint_reg;
  logic [3:0] alarm_reg;

  logic ctl_hit;
  logic mem_hit;
  logic [4:0] mprog;
  logic [5:0] ent;
  logic wr_go;
  logic [31:0] rd_data;
  logic [31:0] wm;
  seq_pkg::status_t status;
  logic signed [15:0] cur_s;
  logic signed [15:0] cur_t;
  logic [13:0] cur_d;
  logic [4:0] cur_link;
  logic tol_on;
  logic over;
  logic wait_ok;
  logic sec_tick;
  logic adv;
  logic seg_done;
  logic finish;
  logic link_ok;
  logic run_rise;
  logic pwr_rise;
  logic in_run;
  logic [3:0] evt;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  assign setpoint = setpoint_reg;
  assign event_alarms = alarm_reg;

  assign ctl_hit = address[13:8] == 6'h00;
  assign mprog = address[12:8];
  assign ent = address[7:2];
  assign mem_hit = address[13] && (mprog < 5'(NPROG));
  assign wr_go = write && !waitrequest;
  assign wm = be_merge(rd_data, writedata, byteenable);

  assign cur_s = sp_mem[prog_reg][seg_reg];
  assign cur_t = sp_mem[prog_reg][seg_reg + 4'h1];
  assign cur_d = dur_mem[prog_reg][seg_reg];
  assign cur_link = link_mem[prog_reg];
  assign tol_on = tol_reg != 16'h0000;
  assign over = tol_on && (absdiff(process_value, setpoint_reg) > {1'b0, tol_reg});
  assign wait_ok = !tol_on ||
                   (absdiff(process_value, sp_mem[prog_reg][0]) <= {1'b0, tol_reg});
  assign sec_tick = sec_cnt_reg == 25'(SEC_CYCLES - 1);
  assign in_run = (state_reg == seq_pkg::SEQ_RUN) && ctrl_reg.run;
  assign pwr_rise = power_ok && !pwr_d_reg;
  assign adv = tick_reg && power_ok && pwr_d_reg && !over;
  assign seg_done = adv && (cur_d != 14'h0) && (elap_reg == cur_d - 14'h0001);
  assign finish = (cur_d == 14'h0) || (seg_done && seg_reg == 4'(NSEG - 1));
  assign link_ok = cur_link < 5'(NPROG);
  assign run_rise = ctrl_reg.run && !run_d_reg && (sel_reg < 5'(NPROG));
  assign evt[`IRQ_SEG] = in_run && seg_done;
  assign evt[`IRQ_LINK] = in_run && finish && link_ok;
  assign evt[`IRQ_END] = in_run && finish && !link_ok;
  assign evt[`IRQ_HOLD] = in_run && over && !hold_reg;

  assign status.state = state_reg;
  assign status.hold = hold_reg;
  assign status.prog = prog_reg;
  assign status.seg = seg_reg;

  always_comb begin
    rd_data = 32'h0000_0000;
    if (ctl_hit) begin
      case (address[7:0])
        `OFS_CTRL: rd_data[1:0] = ctrl_reg;
        `OFS_SEL: rd_data[4:0] = sel_reg;
        `OFS_TOL: rd_data[15:0] = tol_reg;
        `OFS_EVFN: rd_data[3:0] = evfunc_reg;
        `OFS_STAT: rd_data[11:0] = status;
        `OFS_SETPT: rd_data[15:0] = setpoint_reg;
        `OFS_ELAP: rd_data[13:0] = elap_reg;
        `OFS_ISTAT: rd_data[3:0] = irq_stat_reg;
        `OFS_IMASK: rd_data[3:0] = irq_mask_reg;
        default: rd_data = 32'h0000_0000;
      endcase
    end else if (mem_hit) begin
      case (ent[5:4])
        `ENT_SP: if (ent[3:0] <= 4'(NSEG)) rd_data[15:0] = sp_mem[mprog][ent[3:0]];
        `ENT_DUR: if (ent[3:0] < 4'(NSEG)) rd_data[13:0] = dur_mem[mprog][ent[3:0]];
        `ENT_EV: if (ent[3:0] < 4'(NSEG)) rd_data[3:0] = ev_mem[mprog][ent[3:0]];
        default: if (ent[3:0] == 4'h0) rd_data[4:0] = link_mem[mprog];
      endcase
    end
  end

  // One wait state on every access keeps read data registered
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
      if (read && waitrequest) begin
        readdata <= rd_data;
      end
    end
  end

  a_bus_ack: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered after one wait state");

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= '0;
      sel_reg <= 5'h00;
      tol_reg <= 16'h0000;
      evfunc_reg <= 4'h0;
      irq_mask_reg <= 4'h0;
    end else if (wr_go && ctl_hit) begin
      case (address[7:0])
        `OFS_CTRL: ctrl_reg <= seq_pkg::ctrl_t'(wm[1:0]);
        `OFS_SEL: sel_reg <= wm[4:0];
        `OFS_TOL: tol_reg <= wm[15:0];
        `OFS_EVFN: evfunc_reg <= wm[3:0];
        `OFS_IMASK: irq_mask_reg <= wm[3:0];
        default: sel_reg <= sel_reg;
      endcase
    end
  end

  // Set wins over a clear written in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_reg <= 4'h0;
      irq <= 1'b0;
    end else begin
      if (wr_go && ctl_hit && address[7:0] == `OFS_ISTAT) begin
        irq_stat_reg <= (irq_stat_reg & ~(writedata[3:0] & {4{byteenable[0]}})) | evt;
      end else begin
        irq_stat_reg <= irq_stat_reg | evt;
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  a_irq_sticky: assert property (irq_stat_reg[`IRQ_END] && !(wr_go && ctl_hit) |=>
                                 irq_stat_reg[`IRQ_END])
    else $error("sticky status bit lost without a clear");

  // Profile store; durations above the limit are clamped rather than refused
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NPROG; p++) begin
        link_mem[p] <= `NO_LINK;
        for (int s = 0; s <= NSEG; s++) begin
          sp_mem[p][s] <= 16'h0000;
        end
        for (int s = 0; s < NSEG; s++) begin
          dur_mem[p][s] <= 14'h0000;
          ev_mem[p][s] <= 4'h0;
        end
      end
    end else if (wr_go && mem_hit) begin
      case (ent[5:4])
        `ENT_SP: if (ent[3:0] <= 4'(NSEG)) sp_mem[mprog][ent[3:0]] <= wm[15:0];
        `ENT_DUR: if (ent[3:0] < 4'(NSEG)) begin
          dur_mem[mprog][ent[3:0]] <= (wm[15:0] > `DUR_MAX) ? 14'(`DUR_MAX) : wm[13:0];
        end
        `ENT_EV: if (ent[3:0] < 4'(NSEG)) ev_mem[mprog][ent[3:0]] <= wm[3:0];
        default: if (ent[3:0] == 4'h0) link_mem[mprog] <= wm[4:0];
      endcase
    end
  end

  a_dur_limit: assert property (state_reg == seq_pkg::SEQ_RUN |-> cur_d <= 14'(`DUR_MAX))
    else $error("segment duration above limit");

  // Free-running prescaler; the first tick of a segment may come early by up to one base
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sec_cnt_reg <= 25'h000_0000;
      min_cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
    end else begin
      sec_cnt_reg <= sec_tick ? 25'h000_0000 : sec_cnt_reg + 25'h000_0001;
      if (sec_tick) begin
        min_cnt_reg <= (min_cnt_reg == `SECS_PER_MIN) ? 6'h00 : min_cnt_reg + 6'h01;
      end
      tick_reg <= ctrl_reg.minutes ? (sec_tick && min_cnt_reg == `SECS_PER_MIN) : sec_tick;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= seq_pkg::SEQ_IDLE;
      prog_reg <= 5'h00;
      seg_reg <= 4'h0;
      elap_reg <= 14'h0000;
      hold_reg <= 1'b0;
      run_d_reg <= 1'b0;
      pwr_d_reg <= 1'b1;
    end else begin
      run_d_reg <= ctrl_reg.run;
      pwr_d_reg <= power_ok;
      hold_reg <= in_run && over;
      if (!ctrl_reg.run) begin
        state_reg <= seq_pkg::SEQ_IDLE;
      end else if (run_rise) begin
        prog_reg <= sel_reg;
        seg_reg <= 4'h0;
        elap_reg <= 14'h0000;
        state_reg <= tol_on ? seq_pkg::SEQ_WAIT : seq_pkg::SEQ_RUN;
      end else begin
        case (state_reg)
          seq_pkg::SEQ_WAIT: if (wait_ok) state_reg <= seq_pkg::SEQ_RUN;
          seq_pkg::SEQ_RUN: begin
            if (finish) begin
              if (link_ok) begin
                prog_reg <= cur_link;
                seg_reg <= 4'h0;
                elap_reg <= 14'h0000;
              end else begin
                state_reg <= seq_pkg::SEQ_DONE;
              end
            end else if (pwr_rise) begin
              elap_reg <= 14'h0000;
            end else if (seg_done) begin
              seg_reg <= seg_reg + 4'h1;
              elap_reg <= 14'h0000;
            end else if (adv) begin
              elap_reg <= elap_reg + 14'h0001;
            end
          end
          default: state_reg <= state_reg;
        endcase
      end
    end
  end

  a_hold_freeze: assert property (in_run && over && power_ok && pwr_d_reg |=>
                                  $stable(elap_reg))
    else $error("segment timer advanced while out of tolerance");
  a_time_prio: assert property (in_run && tol_reg == 16'h0000 && tick_reg && power_ok &&
                                pwr_d_reg && cur_d > elap_reg + 14'h0001 |=>
                                elap_reg == $past(elap_reg) + 14'h0001)
    else $error("timer did not advance with tolerance off");
  a_zero_end: assert property (in_run && cur_d == 14'h0000 && !link_ok |=>
                               state_reg == seq_pkg::SEQ_DONE)
    else $error("zero duration did not end the program");
  a_link_next: assert property (in_run && finish && link_ok |=>
                                prog_reg == $past(cur_link) && seg_reg == 4'h0 &&
                                state_reg == seq_pkg::SEQ_RUN)
    else $error("linked program not started");
  a_wait_start: assert property (state_reg == seq_pkg::SEQ_WAIT && ctrl_reg.run &&
                                 !wait_ok |=> state_reg != seq_pkg::SEQ_RUN)
    else $error("program started before initial setpoint reached");
  a_pwr_restart: assert property (in_run && !finish && pwr_rise |=>
                                  elap_reg == 14'h0000 && $stable(seg_reg))
    else $error("segment not restarted after power return");

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      setpoint_reg <= 16'h0000;
    end else if (state_reg == seq_pkg::SEQ_WAIT) begin
      setpoint_reg <= sp_mem[prog_reg][0];
    end else if (state_reg == seq_pkg::SEQ_RUN) begin
      if (cur_d == 14'h0000) begin
        setpoint_reg <= cur_s;
      end else if (seg_done) begin
        setpoint_reg <= cur_t;
      end else begin
        setpoint_reg <= ramp(cur_s, cur_t, elap_reg, cur_d);
      end
    end
  end

  // A one-tick segment may finish at elapsed zero, loading the target instead
  a_ramp_start: assert property (state_reg == seq_pkg::SEQ_RUN && elap_reg == 14'h0000 &&
                                 !seg_done &&
                                 $stable(prog_reg) && $stable(seg_reg) && cur_d != 14'h0000 |=>
                                 setpoint_reg == $past(cur_s))
    else $error("segment did not start from previous target");

  // Only alarms configured for event function follow the segment masks
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_reg <= 4'h0;
    end else if (in_run) begin
      alarm_reg <= ev_mem[prog_reg][seg_reg] & evfunc_reg;
    end else begin
      alarm_reg <= 4'h0;
    end
  end

  a_evt_only: assert property ($stable(evfunc_reg) |-> (alarm_reg & ~evfunc_reg) == 4'h0)
    else $error("segment event drove a non-event alarm");

endmodule

// [design/seq_map.svh]
/*
 Offsets, field limits, reset values and timing counts of the profile sequencer.
 Assumes byte addressing on a 32-bit Avalon-MM bus, one register per aligned word.
*/
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH
`define NUM_PROGS 20
`define NUM_SEGS 9
`define DUR_MAX 16'h270F
`define NO_LINK 5'h1F
`define SECS_PER_MIN 6'h3B
`define SEC_NS 1000000000
`define CLK_NS 40
`define SEC_CYCLES (`SEC_NS / `CLK_NS)
`define OFS_CTRL 8'h00
`define OFS_SEL 8'h04
`define OFS_TOL 8'h08
`define OFS_EVFN 8'h0C
`define OFS_STAT 8'h10
`define OFS_SETPT 8'h14
`define OFS_ELAP 8'h18
`define OFS_ISTAT 8'h1C
`define OFS_IMASK 8'h20
`define ENT_SP 2'h0
`define ENT_DUR 2'h1
`define ENT_EV 2'h2
`define ENT_LINK 2'h3
`define IRQ_SEG 0
`define IRQ_LINK 1
`define IRQ_END 2
`define IRQ_HOLD 3
`endif

// [design/seq_pkg.sv]
/*
 Types shared by the profile sequencer: sequence states and register carriers.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package seq_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_WAIT = 2'h1,
    SEQ_RUN = 2'h3,
    SEQ_DONE = 2'h2
  } seq_state_t;
  typedef struct packed {
    logic minutes;
    logic run;
  } ctrl_t;
  typedef struct packed {
    seq_state_t state;
    logic hold;
    logic [4:0] prog;
    logic [3:0] seg;
  } status_t;
endpackage

// [testbench/pv_model.sv]
/*
 Process measurement partner: the measured value slews toward a bench-set level.
 Assumes one clock domain shared with the sequencer and an active-low reset.
*/
`timescale 1ns/1ps
module pv_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic signed [15:0] pv_target,
  input wire logic [15:0] slew,
  output logic signed [15:0] process_value
);
  int diff;
  always_comb begin
    diff = int'(pv_target) - int'(process_value);
  end
  // A real process lags, so the value never jumps further than the slew per cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      process_value <= 16'sh0000;
    end else if (diff > int'(slew)) begin
      process_value <= 16'(int'(process_value) + int'(slew));
    end else if (diff < -int'(slew)) begin
      process_value <= 16'(int'(process_value) - int'(slew));
    end else begin
      process_value <= pv_target;
    end
  end
endmodule

// [testbench/testbench.sv]
/*
 Self-checking bench of the profile sequencer with an integer setpoint model.
 Assumes seq_pkg, the sequencer and pv_model are compiled before this file.
*/
`timescale 1ns/1ps
`include "seq_map.svh"
module testbench;
  localparam logic [13:0] A_CT = {6'h00, `OFS_CTRL};
  localparam logic [13:0] A_SEL = {6'h00, `OFS_SEL};
  localparam logic [13:0] A_TOL = {6'h00, `OFS_TOL};
  localparam logic [13:0] A_ST = {6'h00, `OFS_STAT};
  localparam logic [13:0] A_SP = {6'h00, `OFS_SETPT};
  localparam logic [13:0] A_EL = {6'h00, `OFS_ELAP};
  localparam logic [13:0] A_IS = {6'h00, `OFS_ISTAT};
  localparam logic [13:0] A_IM = {6'h00, `OFS_IMASK};
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [13:0] address = 14'h0000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic signed [15:0] process_value;
  logic power_ok = 1'b1;
  logic signed [15:0] setpoint;
  logic [3:0] event_alarms;
  logic irq;
  logic signed [15:0] pv_target = 16'sh0000;
  logic [15:0] slew = 16'h00C8;
  logic [31:0] rd;
  logic [31:0] e1;
  int n_errors = 0;
  int checks_done = 0;
  int sp[5][10];
  int dur[5][9];
  always #20 mclk = ~mclk;
  ramp_soak_profile_sequencer #(.SEC_CYCLES(64)) i_dut (.mclk(mclk), .arst_n(arst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .process_value(process_value), .power_ok(power_ok), .setpoint(setpoint),
    .event_alarms(event_alarms), .irq(irq));
  pv_model i_pv (.mclk(mclk), .arst_n(arst_n), .pv_target(pv_target), .slew(slew),
    .process_value(process_value));
  task stop_test;
    $display("Checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Request held until the edge that samples waitrequest low
  task bus(input logic w, input logic [13:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge mclk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      $display("Error bus timeout at %h", a);
      n_errors++;
      stop_test();
    end
  endtask
  task wr(input logic [13:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task rg(input logic [13:0] a);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
  endtask
  function automatic logic [13:0] pa(input int p, input int e);
    return 14'(32'h0000_2000 + p * 256 + e * 4);
  endfunction
  task setp(input int p, input int k, input int v);
    sp[p][k] = v;
    wr(pa(p, k), {16'h0000, 16'(v)});
  endtask
  task setd(input int p, input int k, input int v);
    dur[p][k] = v;
    wr(pa(p, 16 + k), 32'(v));
  endtask
  function automatic int xsp(input int k, input int e);
    return sp[0][k] + (sp[0][k + 1] - sp[0][k]) * e / dur[0][k];
  endfunction
  task wbit(input logic [13:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      rg(a);
      n++;
    end while (rd[b] !== v && n < 500);
    if (rd[b] !== v) begin
      $display("Error wait on %h bit %0d", a, b);
      n_errors++;
      stop_test();
    end
  endtask
  // Compares setpoint and alarms only when status and elapsed did not move across the samples
  task snap;
    logic [31:0] s, e, p;
    logic [3:0] al;
    int k;
    rg(A_ST);
    s = rd;
    rg(A_EL);
    e = rd;
    rg(A_SP);
    p = rd;
    al = event_alarms;
    rg(A_ST);
    if (rd === s && s[11:10] === 2'h3) begin
      rg(A_EL);
      k = int'(s[3:0]);
      chk("seg_range", 32'h0000_0001, {31'h0, k < 2});
      if (rd === e && k < 2) begin
        chk("setpoint", {16'h0000, 16'(xsp(k, int'(e)))}, {16'h0000, p[15:0]});
        chk("alarms", (k == 0) ? 32'h0000_0001 : 32'h0000_0002, {28'h0, al});
      end
    end
  endtask
  initial begin
    void'($urandom(13812));
    cyc(6);
    arst_n <= 1'b1;
    cyc(1);
    chk("setpoint_rst", 32'h0000_0000, {16'h0000, setpoint});
    chk("irq_rst", 32'h0000_0000, {31'h0, irq});
    rg(14'h0040);
    chk("unmapped", 32'h0000_0000, rd);
    rg(14'h3900);
    chk("prog_range", 32'h0000_0000, rd);
    wr(pa(19, 16), 32'h0000_FFFF);
    rg(pa(19, 16));
    chk("dur_clamp", {16'h0000, `DUR_MAX}, rd);
    wr(A_EL, 32'h0000_0005);
    rg(A_EL);
    chk("elap_ro", 32'h0000_0000, rd);
    wr(A_TOL, 32'h0000_0000);
    bus(1'b1, A_TOL, 32'h0000_FFFF, 4'h1);
    rg(A_TOL);
    chk("tol_lane", 32'h0000_00FF, rd);
    wr(A_TOL, 32'h0000_0000);
    wr(A_SEL, `NUM_PROGS);
    wr(A_CT, 32'h0000_0001);
    cyc(10);
    rg(A_ST);
    chk("sel_refused", 32'h0000_0000, {30'h0, rd[11:10]});
    wr(A_CT, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      setp(0, k, int'($urandom_range(4000)) - 2000);
    end
    setd(0, 0, 3);
    setd(0, 1, 2);
    setd(0, 2, 0);
    setd(0, 3, 5);
    wr(pa(0, 32), 32'h0000_0005);
    wr(pa(0, 33), 32'h0000_000A);
    wr({6'h00, `OFS_EVFN}, 32'h0000_0003);
    wr(A_IM, 32'h0000_0004);
    wr(A_SEL, 32'h0000_0000);
    wr(A_CT, 32'h0000_0001);
    repeat (12) snap();
    wbit(A_ST, 10, 1'b0);
    chk("state_done", 32'h0000_0002, {30'h0, rd[11:10]});
    rg(A_SP);
    chk("sp_final", {16'h0000, 16'(sp[0][2])}, {16'h0000, rd[15:0]});
    cyc(2);
    chk("irq_end", 32'h0000_0001, {31'h0, irq});
    rg(A_IS);
    chk("istat", 32'h0000_0005, rd);
    wr(A_IS, 32'h0000_0004);
    cyc(2);
    chk("irq_clr", 32'h0000_0000, {31'h0, irq});
    rg(A_IS);
    chk("istat_w1c", 32'h0000_0001, rd);
    wr(A_IM, 32'h0000_0000);
    wr(A_CT, 32'h0000_0000);
    setp(1, 0, 1000);
    setp(1, 1, 1000);
    setd(1, 0, 4);
    wr(A_TOL, 32'h0000_000A);
    slew <= 16'h0008;
    pv_target <= 16'sh0000;
    wr(A_SEL, 32'h0000_0001);
    wr(A_CT, 32'h0000_0001);
    cyc(60);
    rg(A_ST);
    chk("start_wait", 32'h0000_0001, {30'h0, rd[11:10]});
    pv_target <= 16'sd1000;
    wbit(A_ST, 11, 1'b1);
    chk("start_run", 32'h0000_0003, {30'h0, rd[11:10]});
    slew <= 16'h00C8;
    pv_target <= 16'sh0000;
    wbit(A_ST, 9, 1'b1);
    rg(A_EL);
    e1 = rd;
    cyc(300);
    rg(A_EL);
    chk("elap_hold", e1, rd);
    rg(A_IS);
    chk("hold_irq", 32'h0000_0001, {31'h0, rd[3]});
    pv_target <= 16'sd1000;
    wbit(A_ST, 10, 1'b0);
    chk("hold_done", 32'h0000_0002, {30'h0, rd[11:10]});
    wr(A_CT, 32'h0000_0000);
    wr(A_TOL, 32'h0000_0000);
    setp(3, 0, 7);
    setp(3, 1, 300);
    setd(3, 0, 1);
    wr(pa(3, 48), 32'h0000_0004);
    wr(pa(3, 32), 32'h0000_000F);
    setp(4, 0, 300);
    setp(4, 1, -50);
    setd(4, 0, 1);
    wr(pa(4, 48), 32'h0000_0003);
    wr(A_SEL, 32'h0000_0003);
    wr(A_CT, 32'h0000_0001);
    wbit(A_ST, 6, 1'b1);
    wbit(A_ST, 6, 1'b0);
    wr(A_IS, 32'h0000_000F);
    cyc(400);
    rg(A_IS);
    chk("chain_loops", 32'h0000_0002, rd & 32'h0000_0006);
    wr(A_CT, 32'h0000_0000);
    cyc(2);
    chk("alarms_idle", 32'h0000_0000, {28'h0, event_alarms});
    setp(2, 1, 500);
    setd(2, 0, 8);
    wr(A_SEL, 32'h0000_0002);
    wr(A_CT, 32'h0000_0001);
    wbit(A_EL, 1, 1'b1);
    power_ok <= 1'b0;
    cyc(200);
    rg(A_EL);
    e1 = rd;
    cyc(200);
    rg(A_EL);
    chk("elap_off", e1, rd);
    power_ok <= 1'b1;
    cyc(3);
    rg(A_EL);
    chk("elap_rearm", 32'h0000_0001, {31'h0, rd < 2});
    rg(A_ST);
    chk("seg_kept", 32'h0000_0030, {26'h0, rd[11:10], rd[3:0]});
    wr(A_CT, 32'h0000_0000);
    stop_test();
  end
endmodule
